// >>> logic/usbbe_pkg.sv
// Shared constants, types and register map of the USB bulk endpoint engines.
package usbbe_pkg;
  // ==========================================================================
  // Register map, byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CAP = 8'h04;
  localparam logic [7:0] ADDR_DLY = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_BYTES = 8'h10;
  localparam int CFG_W = 4;
  localparam logic [3:0] CFG_RST = 4'h9;
  localparam logic [7:0] CAP_RST = 8'h00;

  // ==========================================================================
  // Timing: bulk-in delay is programmed in microseconds.
  localparam int CLK_PERIOD_NS = 100;
  localparam int DLY_UNIT_NS = 1000;
  localparam int DLY_UNIT_CYC = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_DEF_US = 34;

  // ==========================================================================
  // Packet sizes, burst limit bounds and transmit FIFO thresholds.
  localparam logic [9:0] MPS_HS = 10'h200;
  localparam logic [9:0] MPS_FS = 10'h040;
  localparam logic [7:0] CAP_HS_MIN = 8'h04;
  localparam logic [7:0] CAP_FS_MIN = 8'h20;
  localparam logic [16:0] CAP_HS_SLACK = 17'h00004;
  localparam logic [15:0] FREE_ACK = 16'h0400;
  localparam logic [15:0] FREE_NYET = 16'h0200;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {IN_NONE, IN_NAK, IN_DATA, IN_ZLP} usbbe_in_resp_t;
  typedef enum logic [2:0] {OUT_NONE, OUT_ACK, OUT_NYET, OUT_NAK, OUT_STALL} usbbe_out_resp_t;
  typedef enum logic {TX_IDLE, TX_WAIT} usbbe_tx_state_t;
  typedef struct packed {
    logic syncStall;
    logic emptyNak;
    logic capEn;
    logic multi;
  } usbbe_cfg_t;
  typedef struct packed {
    logic [15:0] headRem;
    logic [15:0] nextBytes;
  } usbbe_rxq_t;
  typedef struct packed {
    usbbe_in_resp_t resp;
    logic [9:0] len;
    logic frameEnd;
  } usbbe_in_pkt_t;
endpackage

// >>> logic/usbbe_bulk_out_receiver.sv
// Bulk Out receiver: handshake choice, rewind of bad packets and sync stall.
`timescale 1ns/1ps
module usbbe_bulk_out_receiver
  import usbbe_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Packet and token events from the protocol engine.
  input wire logic outPktOk,
  input wire logic outPktErr,
  input wire logic pingToken,
  input wire logic stallClear,
  // FIFO controller status and configuration.
  input wire logic [15:0] txFree,
  input wire logic syncLost,
  input wire logic stallEnable,
  // Answers.
  output usbbe_out_resp_t outResp,
  output logic txRewind,
  output logic outStalled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Stall state; a loss of sync in the clearing cycle still stalls.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      outStalled <= 1'b0;
    else if (syncLost && stallEnable)
      outStalled <= 1'b1;
    else if (stallClear)
      outStalled <= 1'b0;
  end

  // Handshake per packet; a NAKed packet is rewound so nothing half lands.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      outResp <= OUT_NONE;
      txRewind <= 1'b0;
    end
    else
    begin
      outResp <= OUT_NONE;
      txRewind <= 1'b0;
      if (outPktErr)
        txRewind <= 1'b1;
      else if ((outPktOk || pingToken) && outStalled)
        outResp <= OUT_STALL;
      else if (outPktOk)
      begin
        if (txFree >= FREE_ACK)
          outResp <= OUT_ACK;
        else if (txFree >= FREE_NYET)
          outResp <= OUT_NYET;
        else
        begin
          outResp <= OUT_NAK;
          txRewind <= 1'b1;
        end
      end
      else if (pingToken)
        outResp <= (txFree >= FREE_NYET) ? OUT_ACK : OUT_NAK;
    end
  end

  a_err_silent_rewind: assert property (outPktErr |=> outResp == OUT_NONE && txRewind)
    else $error("errored packet was answered or not rewound");
  a_sync_loss_stall: assert property (syncLost && stallEnable |=> outStalled [*2])
    else $error("loss of sync did not stall");
  a_ack_room: assert property (outPktOk && !outPktErr && !outStalled && txFree >= FREE_ACK
    |=> outResp == OUT_ACK)
    else $error("ample space not acknowledged");
endmodule

// >>> logic/usbbe_top.sv
// Bulk In transmitter, AHB-Lite register slave and the Bulk Out receiver.
`timescale 1ns/1ps
module usbbe_top
  import usbbe_pkg::*;
#(
  parameter int DLY_RST_US = DLY_DEF_US
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bulk In token side.
  input wire logic hsMode,
  input wire logic inToken,
  input wire logic inAck,
  input wire logic inNoAck,
  output usbbe_in_pkt_t inPkt,
  // Receive FIFO controller.
  input usbbe_rxq_t rxQueue,
  output logic rxRewind,
  output logic rxAdvance,
  output logic [9:0] rxAdvLen,
  // Bulk Out side.
  input wire logic outPktOk,
  input wire logic outPktErr,
  input wire logic pingToken,
  input wire logic stallClear,
  input wire logic [15:0] txFree,
  input wire logic syncLost,
  output usbbe_out_resp_t outResp,
  output logic txRewind,
  output logic outStalled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  usbbe_cfg_t cfg_r;
  logic [7:0] cap_r;
  logic [15:0] dlySet_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  usbbe_tx_state_t state_r;
  usbbe_in_pkt_t saved_r;
  usbbe_in_pkt_t pkt_nxt;
  logic [19:0] burst_r;
  logic [19:0] dlyCnt_r;
  logic zlpDue_r;
  logic midFrame_r;
  logic hadData_r;
  logic [9:0] maxPkt;
  logic [1:0] pad;
  logic [17:0] headPad;
  logic [17:0] streamAll;
  logic [17:0] streamLen;
  logic [9:0] pktLen;
  logic [16:0] capBytes;
  logic [16:0] capLow;
  logic capOn;
  logic capHit;
  logic dlyBusy;
  logic fullAvail;
  logic [19:0] dlyCyc;
  logic tokIdle;
  logic ackFull;

  // ==========================================================================
  // AHB-Lite slave. Zero wait states; a read issued right behind a write to
  // the same register sees the old value, the usual price of no stalling.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_r <= hsel && htrans[1] && hready && hwrite;
      wrAddr_r <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        if (haddr[7:0] == ADDR_CFG)
          hrdata <= {28'h0000_000, cfg_r};
        else if (haddr[7:0] == ADDR_CAP)
          hrdata <= {24'h00_0000, cap_r};
        else if (haddr[7:0] == ADDR_DLY)
          hrdata <= {16'h0000, dlySet_r};
        else if (haddr[7:0] == ADDR_STAT)
          hrdata <= {27'h000_0000, capOn, outStalled, zlpDue_r, dlyBusy,
                     state_r == TX_WAIT};
        else if (haddr[7:0] == ADDR_BYTES)
          hrdata <= {12'h000, burst_r};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end
  // Register writes land in the data phase.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_r <= usbbe_cfg_t'(CFG_RST);
      cap_r <= CAP_RST;
      dlySet_r <= 16'(DLY_RST_US);
    end
    else if (wrPend_r)
    begin
      if (wrAddr_r == ADDR_CFG)
        cfg_r <= usbbe_cfg_t'(hwdata[CFG_W-1:0]);
      else if (wrAddr_r == ADDR_CAP)
        cap_r <= hwdata[7:0];
      else if (wrAddr_r == ADDR_DLY)
        dlySet_r <= hwdata[15:0];
    end
  end

  // ==========================================================================
  // Packet sizing from the FIFO controller's view of the queued frames.
  always_comb
  begin
    maxPkt = hsMode ? MPS_HS : MPS_FS;
    pad = (cfg_r.multi && rxQueue.nextBytes != 16'h0000)
        ? 2'(~rxQueue.headRem[1:0] + 2'h1) : 2'h0;
    headPad = 18'(rxQueue.headRem) + 18'(pad);
    streamAll = headPad + 18'(rxQueue.nextBytes);
    capOn = cfg_r.capEn && (hsMode ? (cap_r > CAP_HS_MIN) : (cap_r > CAP_FS_MIN));
    capBytes = hsMode ? {cap_r, 9'h000} : {3'h0, cap_r, 6'h00};
    capLow = hsMode ? capBytes - CAP_HS_SLACK : capBytes;
    capHit = capOn && !midFrame_r && ({3'h0, capLow} <= burst_r);
    if (!cfg_r.multi)
      streamLen = 18'(rxQueue.headRem);
    else if (capOn && (21'(burst_r) + 21'(streamAll)) > 21'(capBytes))
      streamLen = 18'(rxQueue.headRem);
    else
      streamLen = streamAll;
    pktLen = (streamLen >= 18'(maxPkt)) ? maxPkt : streamLen[9:0];
    fullAvail = pktLen == maxPkt;
    dlyBusy = dlyCnt_r != 20'h00000;
    dlyCyc = 20'(dlySet_r * DLY_UNIT_CYC);
    tokIdle = inToken && state_r == TX_IDLE;
  end
  // Answer to the token now at hand, in order of precedence.
  always_comb
  begin
    pkt_nxt.resp = IN_NAK;
    pkt_nxt.len = 10'h000;
    pkt_nxt.frameEnd = 1'b0;
    if (state_r == TX_WAIT)
      pkt_nxt = saved_r;
    else if (!cfg_r.multi && zlpDue_r)
      pkt_nxt.resp = IN_ZLP;
    else if (fullAvail && !capHit)
    begin
      pkt_nxt.resp = IN_DATA;
      pkt_nxt.len = pktLen;
    end
    else if (cfg_r.multi && dlyBusy)
      pkt_nxt.resp = IN_NAK;
    else if (capHit)
      pkt_nxt.resp = IN_ZLP;
    else if (pktLen != 10'h000)
    begin
      pkt_nxt.resp = IN_DATA;
      pkt_nxt.len = pktLen;
    end
    else if (zlpDue_r)
      pkt_nxt.resp = IN_ZLP;
    else
      pkt_nxt.resp = cfg_r.emptyNak ? IN_NAK : IN_ZLP;
    if (state_r == TX_IDLE && pkt_nxt.resp == IN_DATA)
      pkt_nxt.frameEnd = (18'(pkt_nxt.len) == streamLen)
                      || (cfg_r.multi && 18'(pkt_nxt.len) == headPad);
  end
  assign ackFull = state_r == TX_WAIT && inAck && saved_r.resp == IN_DATA
                && saved_r.len == maxPkt;

  // ==========================================================================
  // Transfer state: a sent packet is held until the host acknowledges it.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= TX_IDLE;
      saved_r <= '{IN_NONE, 10'h000, 1'b0};
      inPkt <= '{IN_NONE, 10'h000, 1'b0};
    end
    else
    begin
      inPkt <= inToken ? pkt_nxt : usbbe_in_pkt_t'{IN_NONE, 10'h000, 1'b0};
      case (state_r)
        TX_IDLE:
          if (inToken && pkt_nxt.resp != IN_NAK)
          begin
            state_r <= TX_WAIT;
            saved_r <= pkt_nxt;
          end
        TX_WAIT:
          if (inAck)
            state_r <= TX_IDLE;
        default:
          state_r <= TX_IDLE;
      endcase
    end
  end
  // FIFO controller notifications after each handshake outcome.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxRewind <= 1'b0;
      rxAdvance <= 1'b0;
      rxAdvLen <= 10'h000;
    end
    else
    begin
      rxRewind <= state_r == TX_WAIT && inNoAck;
      rxAdvance <= state_r == TX_WAIT && inAck && saved_r.resp == IN_DATA;
      rxAdvLen <= (state_r == TX_WAIT && inAck) ? saved_r.len : 10'h000;
    end
  end
  // Burst bookkeeping, updated only on acknowledged packets.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      burst_r <= 20'h00000;
      zlpDue_r <= 1'b0;
      midFrame_r <= 1'b0;
    end
    else if (state_r == TX_WAIT && inAck)
    begin
      if (ackFull)
      begin
        burst_r <= (burst_r > 20'hffdff) ? 20'hfffff : burst_r + 20'(saved_r.len);
        zlpDue_r <= cfg_r.multi || saved_r.frameEnd;
        midFrame_r <= !saved_r.frameEnd;
      end
      else
      begin
        burst_r <= 20'h00000;
        zlpDue_r <= 1'b0;
        midFrame_r <= 1'b0;
      end
    end
  end

  // Delay timer; a zero setting loads zero, so it never runs.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dlyCnt_r <= 20'h00000;
      hadData_r <= 1'b0;
    end
    else
    begin
      hadData_r <= streamAll != 18'h00000;
      if (cfg_r.multi && ackFull)
        dlyCnt_r <= dlyCyc;
      else if (cfg_r.multi && state_r == TX_IDLE && !hadData_r
               && streamAll != 18'h00000 && !fullAvail)
        dlyCnt_r <= dlyCyc;
      else if (dlyBusy)
        dlyCnt_r <= dlyCnt_r - 20'h00001;
    end
  end

  // ==========================================================================
  // Bulk Out receiver.
  usbbe_bulk_out_receiver u_out (
    .clk(clk),
    .rst_b(rst_b),
    .outPktOk(outPktOk),
    .outPktErr(outPktErr),
    .pingToken(pingToken),
    .stallClear(stallClear),
    .txFree(txFree),
    .syncLost(syncLost),
    .stallEnable(cfg_r.syncStall),
    .outResp(outResp),
    .txRewind(txRewind),
    .outStalled(outStalled)
  );

  a_resend_same_pkt: assert property (state_r == TX_WAIT && inToken |=> inPkt == $past(saved_r))
    else $error("pending packet not repeated");
  a_noack_rewind: assert property (state_r == TX_WAIT && inNoAck |=> rxRewind && !rxAdvance)
    else $error("missing ACK did not rewind");
  a_ack_advance: assert property (state_r == TX_WAIT && inAck && saved_r.resp == IN_DATA
    |=> rxAdvance && rxAdvLen == $past(saved_r.len))
    else $error("ACK did not advance by packet length");
  a_delay_nak: assert property (tokIdle && cfg_r.multi && dlyBusy && !fullAvail && !zlpDue_r
    |=> inPkt.resp == IN_NAK)
    else $error("token not NAKed during delay");
  a_sef_no_pad: assert property (tokIdle && !cfg_r.multi
    |=> inPkt.len <= $past(rxQueue.headRem))
    else $error("single-frame packet ran past frame end");
  a_cap_zlp: assert property (tokIdle && capHit && !(cfg_r.multi && dlyBusy)
    && !(!cfg_r.multi && zlpDue_r) |=> inPkt.resp == IN_ZLP)
    else $error("burst limit not ended by ZLP");
  a_empty_zlp: assert property (tokIdle && streamAll == 18'h00000 && !zlpDue_r && !dlyBusy
    && !capHit && !cfg_r.emptyNak |=> inPkt.resp == IN_ZLP)
    else $error("empty FIFO token not answered with ZLP");
endmodule

// >>> sim/usbbe_fifo_model.sv
// Receive FIFO controller model facing the bulk endpoint engines.
`timescale 1ns/1ps
module usbbe_fifo_model
  import usbbe_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Frame arrivals from the bench.
  input wire logic push,
  input wire logic [15:0] pushLen,
  // Read pointer control from the transmitter.
  input wire logic rxAdvance,
  input wire logic [9:0] rxAdvLen,
  output usbbe_rxq_t rxQueue
);
  // ==========================================================================
  // Queue state
  logic [15:0] padLen;
  logic [15:0] used;

  // The head frame is padded only when a frame follows it.
  assign padLen = (rxQueue.nextBytes != 16'h0000) ? ((16'h0000 - rxQueue.headRem) & 16'h0003)
                                                  : 16'h0000;
  assign used = rxQueue.headRem + padLen;

  // Frames queued behind the head merge into one count, which is enough for short runs.
  // status length, grows on push, shrinks only on ACK
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rxQueue <= '0;
    else if (push && rxQueue == '0)
      rxQueue.headRem <= pushLen;
    else if (push)
      rxQueue.nextBytes <= rxQueue.nextBytes + pushLen;
    else if (rxAdvance && 16'(rxAdvLen) < used)
      rxQueue.headRem <= rxQueue.headRem - 16'(rxAdvLen);
    else if (rxAdvance)
      rxQueue <= '{headRem: rxQueue.nextBytes - (16'(rxAdvLen) - used), nextBytes: 16'h0000};
  end
endmodule

// >>> sim/usbbe_top_test.sv
// Self-checking bench for the USB bulk endpoint engines.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin nErrors++; \
  $display("wrong value %s exp %h got %h", nm, ex, got); end end
module usbbe_top_test
  import usbbe_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, hsMode, inToken, inAck, inNoAck;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic rxRewind, rxAdvance, outPktOk, outPktErr, pingToken, stallClear, syncLost;
  logic txRewind, outStalled, push;
  logic [9:0] rxAdvLen;
  logic [15:0] txFree, pushLen;
  usbbe_in_pkt_t inPkt;
  usbbe_rxq_t rxQueue;
  usbbe_out_resp_t outResp;
  int nErrors = 0;
  int numChecks = 0;

  usbbe_top #(.DLY_RST_US(DLY_DEF_US)) dut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hsMode(hsMode), .inToken(inToken), .inAck(inAck), .inNoAck(inNoAck), .inPkt(inPkt),
    .rxQueue(rxQueue), .rxRewind(rxRewind), .rxAdvance(rxAdvance), .rxAdvLen(rxAdvLen),
    .outPktOk(outPktOk), .outPktErr(outPktErr), .pingToken(pingToken),
    .stallClear(stallClear), .txFree(txFree), .syncLost(syncLost), .outResp(outResp),
    .txRewind(txRewind), .outStalled(outStalled));

  usbbe_fifo_model fifo (.clk(clk), .rst_b(rst_b), .push(push), .pushLen(pushLen),
    .rxAdvance(rxAdvance), .rxAdvLen(rxAdvLen), .rxQueue(rxQueue));

  // ==========================================================================
  // Bus and handshake tasks
  task automatic tallyAndFinish();
    if (nErrors == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Address phase is held until hready, then the data phase until hready again.
  // Select stays up between transfers; an idle htrans is enough to end one.
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                     input logic [31:0] ex);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!wr) `CHK("hrdata", ex, hrdata)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // The answer stands for one cycle only, so it is read just after the edge.
  task automatic tok(input usbbe_in_resp_t er, input logic [9:0] el, input logic ef);
    @(posedge clk);
    inToken <= 1'b1;
    @(posedge clk);
    inToken <= 1'b0;
    #1;
    `CHK("inPkt.resp", er, inPkt.resp)
    if (er == IN_DATA)
    begin
      `CHK("inPkt.len", el, inPkt.len)
      `CHK("inPkt.frameEnd", ef, inPkt.frameEnd)
    end
  endtask

  task automatic ack(input logic ok, input logic [9:0] el);
    @(posedge clk);
    inAck <= ok;
    inNoAck <= !ok;
    @(posedge clk);
    inAck <= 1'b0;
    inNoAck <= 1'b0;
    #1;
    `CHK("rxRewind", !ok, rxRewind)
    `CHK("rxAdvance", ok && el != 10'h000, rxAdvance)
    if (ok && el != 10'h000) `CHK("rxAdvLen", el, rxAdvLen)
  endtask

  task automatic pushF(input logic [15:0] n);
    @(posedge clk);
    push <= 1'b1;
    pushLen <= n;
    @(posedge clk);
    push <= 1'b0;
    @(posedge clk);
  endtask

  // Kind 0 is a good packet, 1 an errored one, 2 a ping.
  task automatic outEv(input int k, input logic [15:0] fr, input usbbe_out_resp_t er,
                       input logic erw);
    @(posedge clk);
    txFree <= fr;
    outPktOk <= (k == 0);
    outPktErr <= (k == 1);
    pingToken <= (k == 2);
    @(posedge clk);
    outPktOk <= 1'b0;
    outPktErr <= 1'b0;
    pingToken <= 1'b0;
    #1;
    `CHK("outResp", er, outResp)
    `CHK("txRewind", erw, txRewind)
  endtask

  task automatic pulseSync(input logic clr, input logic exp);
    @(posedge clk);
    syncLost <= !clr;
    stallClear <= clr;
    @(posedge clk);
    syncLost <= 1'b0;
    stallClear <= 1'b0;
    #1;
    `CHK("outStalled", exp, outStalled)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sRegs();
    ahb(ADDR_CFG, 1'b0, 32'h0, {28'h0, CFG_RST});
    ahb(ADDR_CAP, 1'b0, 32'h0, {24'h0, CAP_RST});
    ahb(ADDR_DLY, 1'b0, 32'h0, 32'(DLY_DEF_US));
    ahb(8'h20, 1'b1, 32'hffffffff, 32'h0);
    ahb(8'h20, 1'b0, 32'h0, 32'h0);
    ahb(ADDR_DLY, 1'b1, 32'h0, 32'h0);
    ahb(ADDR_DLY, 1'b0, 32'h0, 32'h0);
  endtask

  task automatic sEmpty();
    ahb(ADDR_CFG, 1'b1, 32'h8, 32'h0);
    tok(IN_ZLP, 10'h000, 1'b0);
    ack(1'b1, 10'h000);
    ahb(ADDR_CFG, 1'b1, 32'hc, 32'h0);
    tok(IN_NAK, 10'h000, 1'b0);
    ahb(ADDR_CFG, 1'b1, 32'h8, 32'h0);
  endtask

  task automatic sSingle();
    pushF(16'd100);
    pushF(16'd50);
    tok(IN_DATA, 10'd100, 1'b1);
    ack(1'b0, 10'h000);
    tok(IN_DATA, 10'd100, 1'b1);
    ack(1'b1, 10'd100);
    tok(IN_DATA, 10'd50, 1'b1);
    ack(1'b1, 10'd50);
    pushF(16'd512);
    tok(IN_DATA, MPS_HS, 1'b1);
    ack(1'b1, MPS_HS);
    pushF(16'd20);
    tok(IN_ZLP, 10'h000, 1'b0);
    ack(1'b1, 10'h000);
    tok(IN_DATA, 10'd20, 1'b1);
    ack(1'b1, 10'd20);
  endtask

  task automatic sFull();
    hsMode <= 1'b0;
    pushF(16'd100);
    tok(IN_DATA, MPS_FS, 1'b0);
    ack(1'b1, MPS_FS);
    ahb(ADDR_BYTES, 1'b0, 32'h0, {22'h0, MPS_FS});
    tok(IN_DATA, 10'd36, 1'b1);
    ack(1'b1, 10'd36);
    hsMode <= 1'b1;
  endtask

  task automatic sMulti();
    ahb(ADDR_CFG, 1'b1, 32'h9, 32'h0);
    pushF(16'd10);
    pushF(16'd20);
    tok(IN_DATA, 10'd32, 1'b1);
    ack(1'b1, 10'd32);
    pushF(16'd10);
    tok(IN_DATA, 10'd10, 1'b1);
    ack(1'b1, 10'd10);
  endtask

  // One microsecond of delay is ten cycles at this clock.
  task automatic sDelay();
    ahb(ADDR_DLY, 1'b1, 32'h1, 32'h0);
    pushF(16'd40);
    tok(IN_NAK, 10'h000, 1'b0);
    ahb(ADDR_STAT, 1'b0, 32'h0, 32'h2);
    repeat (12) @(posedge clk);
    tok(IN_DATA, 10'd40, 1'b1);
    ack(1'b1, 10'd40);
    ahb(ADDR_DLY, 1'b1, 32'h0, 32'h0);
  endtask

  task automatic sOut();
    outEv(0, 16'd2000, OUT_ACK, 1'b0);
    outEv(0, FREE_ACK, OUT_ACK, 1'b0);
    outEv(0, 16'd1023, OUT_NYET, 1'b0);
    outEv(0, FREE_NYET, OUT_NYET, 1'b0);
    outEv(0, 16'd511, OUT_NAK, 1'b1);
    outEv(2, 16'd600, OUT_ACK, 1'b0);
    outEv(2, 16'd100, OUT_NAK, 1'b0);
    outEv(1, 16'd2000, OUT_NONE, 1'b1);
    pulseSync(1'b0, 1'b1);
    outEv(0, 16'd2000, OUT_STALL, 1'b0);
    pulseSync(1'b1, 1'b0);
    ahb(ADDR_CFG, 1'b1, 32'h1, 32'h0);
    pulseSync(1'b0, 1'b0);
  endtask

  // A limit of four is ignored; five full packets reach a limit of five, and the
  // frame queued behind waits for the next burst instead of being split.
  task automatic sCap();
    ahb(ADDR_CFG, 1'b1, 32'h3, 32'h0);
    ahb(ADDR_CAP, 1'b1, 32'h4, 32'h0);
    ahb(ADDR_STAT, 1'b0, 32'h0, 32'h0);
    ahb(ADDR_CAP, 1'b1, 32'h5, 32'h0);
    ahb(ADDR_STAT, 1'b0, 32'h0, 32'h10);
    pushF(16'd2560);
    pushF(16'd100);
    repeat (4)
    begin
      tok(IN_DATA, MPS_HS, 1'b0);
      ack(1'b1, MPS_HS);
    end
    tok(IN_DATA, MPS_HS, 1'b1);
    ack(1'b1, MPS_HS);
    tok(IN_ZLP, 10'h000, 1'b0);
    ack(1'b1, 10'h000);
    tok(IN_DATA, 10'd100, 1'b1);
    ack(1'b1, 10'd100);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The whole run needs about two hundred cycles; twenty thousand marks a hang.
  initial
  begin
    #2000000;
    nErrors++;
    tallyAndFinish();
  end

  initial
  begin
    {rst_b, hsel, hwrite, inToken, inAck, inNoAck, push} = '0;
    {outPktOk, outPktErr, pingToken, stallClear, syncLost} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsMode = 1'b1;
    txFree = 16'h0000;
    pushLen = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    sRegs();
    sEmpty();
    sSingle();
    sFull();
    sMulti();
    sDelay();
    sOut();
    sCap();
    tallyAndFinish();
  end
endmodule
